// ### rtl/rtcpc_params.svh
`ifndef RTCPC_PARAMS_SVH
`define RTCPC_PARAMS_SVH

`define RTCPC_CTRL_ADDR 8'h0e
`define RTCPC_CTRL_RESET 8'h1c
`define RTCPC_BIT_OSC_HALT 7
`define RTCPC_BIT_RATE_HI 4
`define RTCPC_BIT_RATE_LO 3
`define RTCPC_BIT_IRQ_SEL 2
`define RTCPC_BIT_A2_EN 1
`define RTCPC_BIT_A1_EN 0
`define RTCPC_CLK_MHZ 100
`define RTCPC_DEBOUNCE_MS 250
`define RTCPC_RST_ACTIVE_MS 250
`define RTCPC_RECOVERY_MS 300
`define RTCPC_MS_CYCLES (`RTCPC_CLK_MHZ * 1000)
`define RTCPC_RATE_1HZ 2'h0
`define RTCPC_RATE_4K 2'h1
`define RTCPC_RATE_8K 2'h2
`define RTCPC_RATE_32K 2'h3
`define RTCPC_MEM_AW 13
`define RTCPC_MEM_DEPTH 8192

`endif

// ### rtl/rtcpc_pkg.sv
package rtcpc_pkg;

  typedef enum logic [2:0] {
    RTCPC_IDLE = 3'h0,
    RTCPC_DEBOUNCE = 3'h1,
    RTCPC_WAIT_RISE = 3'h3,
    RTCPC_HOLD = 3'h2,
    RTCPC_POWER_FAIL = 3'h6,
    RTCPC_RECOVER = 3'h7
  } rtcpc_state_type;

  typedef struct packed {
    logic we;
    logic [12:0] addr;
    logic [7:0] wdata;
  } rtcpc_mem_req_type;

  typedef struct packed {
    logic alarm1_match;
    logic alarm2_match;
    logic tick_1hz;
    logic tick_4k;
    logic tick_8k;
    logic tick_32k;
  } rtcpc_time_type;

endpackage

// ### rtl/rtcpc_mem.sv
`timescale 1ns/10ps
`include "rtcpc_params.svh"

module rtcpc_mem
  import rtcpc_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic write_allow, // High when a write may land
  input wire rtcpc_mem_req_type req, // Access request
  output logic [7:0] rdata // Registered read data
);

  logic [7:0] store [0:`RTCPC_MEM_DEPTH-1];

  always_ff @(posedge ref_clk) begin
    if (req.we && write_allow) begin
      store[req.addr] <= req.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    rdata <= store[req.addr];
  end

endmodule

// ### rtl/rtcpc_interval.sv
`timescale 1ns/10ps
`include "rtcpc_params.svh"

module rtcpc_interval #(
  parameter int unsigned CYCLES = 1
) (
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Async reset, active low
  input wire logic start, // Restart the interval
  output logic done // Pulse when the interval ends
);

  logic [31:0] count;
  logic running;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 32'h0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= CYCLES - 32'h1;
        running <= 1'b1;
      end else if (running) begin
        if (count == 32'h0) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 32'h1;
        end
      end
    end
  end

endmodule

// ### rtl/rtcpc_top.sv
`timescale 1ns/10ps
`include "rtcpc_params.svh"

module rtcpc_top
  import rtcpc_pkg::*;
(
  input wire logic ref_clk, // Internal oscillator clock, 100 MHz
  input wire logic arst_n, // Power-up reset, active low
  input wire logic write_protect, // Write-protect input, high blocks array writes
  input wire logic reg_we, // Host register write strobe
  input wire logic [7:0] reg_addr, // Host register address
  input wire logic [7:0] reg_wdata, // Host register write data
  output logic [7:0] reg_rdata, // Registered register read data
  input wire rtcpc_mem_req_type mem_req, // Host array access
  output logic [7:0] mem_rdata, // Registered array read data
  input wire rtcpc_time_type time_in, // Alarm matches and divider ticks
  input wire logic supply_low, // Supply below power_fail_threshold
  input wire logic on_backup, // Running from backup supply
  input wire logic ref_out_enable, // Enable for the reference clock output
  input wire logic reset_pin_in, // Level seen on the reset pin
  output logic reset_pin_oe, // Pulls reset pin low when high
  output logic irq_wave_pin_oe, // Pulls irq_wave_pin low when high
  output logic calibrated_ref_oe // Pulls calibrated_ref_out low when high
);

  logic [7:0] control_register;
  logic irq_or_wave_select;
  logic osc_halt_bit;
  logic [1:0] wave_rate;
  rtcpc_state_type state;
  rtcpc_state_type next_state;
  logic pin_prev;
  logic start_debounce;
  logic start_hold;
  logic start_recover;
  logic debounce_done;
  logic hold_done;
  logic recover_done;
  logic wave_level;
  logic wave_sel_tick;
  logic alarm_fire;
  logic [7:0] mem_rdata_raw;

  assign irq_or_wave_select = control_register[`RTCPC_BIT_IRQ_SEL];
  assign osc_halt_bit = control_register[`RTCPC_BIT_OSC_HALT];
  assign wave_rate = {control_register[`RTCPC_BIT_RATE_HI], control_register[`RTCPC_BIT_RATE_LO]};

  // Control register; power-up value sets select and clears alarm enables
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      control_register <= `RTCPC_CTRL_RESET;
    end else if (reg_we && reg_addr == `RTCPC_CTRL_ADDR) begin
      control_register <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == `RTCPC_CTRL_ADDR) begin
      reg_rdata <= control_register;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // A floating write-protect pin is resolved low by the pad pulldown
  rtcpc_mem u_mem (
    .ref_clk(ref_clk),
    .write_allow(!write_protect),
    .req(mem_req),
    .rdata(mem_rdata_raw)
  );

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_rdata <= 8'h00;
    end else begin
      mem_rdata <= mem_rdata_raw;
    end
  end

  always_comb begin
    case (wave_rate)
      `RTCPC_RATE_1HZ: wave_sel_tick = time_in.tick_1hz;
      `RTCPC_RATE_4K: wave_sel_tick = time_in.tick_4k;
      `RTCPC_RATE_8K: wave_sel_tick = time_in.tick_8k;
      `RTCPC_RATE_32K: wave_sel_tick = time_in.tick_32k;
      default: wave_sel_tick = 1'b0;
    endcase
  end

  assign alarm_fire = (time_in.alarm1_match && control_register[`RTCPC_BIT_A1_EN])
    || (time_in.alarm2_match && control_register[`RTCPC_BIT_A2_EN]);

  // Ticks mark half periods, so toggling yields a square wave
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wave_level <= 1'b0;
    end else if (wave_sel_tick) begin
      wave_level <= !wave_level;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_wave_pin_oe <= 1'b0;
    end else if (irq_or_wave_select) begin
      irq_wave_pin_oe <= alarm_fire;
    end else begin
      irq_wave_pin_oe <= !wave_level;
    end
  end

  // Reference output keeps running on backup supply; on_backup is not a gate
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      calibrated_ref_oe <= 1'b0;
    end else if (ref_out_enable || on_backup && ref_out_enable) begin
      calibrated_ref_oe <= (time_in.tick_32k ? calibrated_ref_oe ^ 1'b1 : calibrated_ref_oe);
    end else begin
      calibrated_ref_oe <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_prev <= 1'b1;
    end else begin
      pin_prev <= reset_pin_in;
    end
  end

  rtcpc_interval #(.CYCLES(`RTCPC_DEBOUNCE_MS * `RTCPC_MS_CYCLES)) u_debounce (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .start(start_debounce),
    .done(debounce_done)
  );

  rtcpc_interval #(.CYCLES(`RTCPC_RST_ACTIVE_MS * `RTCPC_MS_CYCLES)) u_hold (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .start(start_hold),
    .done(hold_done)
  );

  rtcpc_interval #(.CYCLES(`RTCPC_RECOVERY_MS * `RTCPC_MS_CYCLES)) u_recover (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .start(start_recover),
    .done(recover_done)
  );

  // Power fail overrides any pushbutton sequence in progress
  always_comb begin
    next_state = state;
    start_debounce = 1'b0;
    start_hold = 1'b0;
    start_recover = 1'b0;
    case (state)
      RTCPC_IDLE: begin
        if (supply_low) begin
          next_state = RTCPC_POWER_FAIL;
        end else if (pin_prev && !reset_pin_in) begin
          next_state = RTCPC_DEBOUNCE;
          start_debounce = 1'b1;
        end
      end
      RTCPC_DEBOUNCE: begin
        if (supply_low) begin
          next_state = RTCPC_POWER_FAIL;
        end else if (debounce_done) begin
          next_state = RTCPC_WAIT_RISE;
        end
      end
      RTCPC_WAIT_RISE: begin
        if (supply_low) begin
          next_state = RTCPC_POWER_FAIL;
        end else if (reset_pin_in) begin
          next_state = RTCPC_HOLD;
          start_hold = 1'b1;
        end
      end
      RTCPC_HOLD: begin
        if (supply_low) begin
          next_state = RTCPC_POWER_FAIL;
        end else if (hold_done) begin
          next_state = RTCPC_IDLE;
        end
      end
      RTCPC_POWER_FAIL: begin
        if (!supply_low) begin
          if (osc_halt_bit) begin
            next_state = RTCPC_IDLE;
          end else begin
            next_state = RTCPC_RECOVER;
            start_recover = 1'b1;
          end
        end
      end
      RTCPC_RECOVER: begin
        if (supply_low) begin
          next_state = RTCPC_POWER_FAIL;
        end else if (recover_done) begin
          next_state = RTCPC_IDLE;
        end
      end
      default: next_state = RTCPC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= RTCPC_POWER_FAIL;
    end else begin
      state <= next_state;
    end
  end

  // Wait-for-release releases the pulldown, else the button could not be seen rising
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_pin_oe <= 1'b1;
    end else begin
      reset_pin_oe <= (next_state != RTCPC_IDLE) && (next_state != RTCPC_WAIT_RISE);
    end
  end

endmodule

// ### test/rtcpc_asserts.sv
`timescale 1ns/10ps
module rtcpc_asserts
  import rtcpc_pkg::*;
(
  input wire logic ref_clk, // clk
  input wire logic arst_n, // rst
  input wire logic write_protect, // wp
  input wire logic reg_we, // we
  input wire logic [7:0] reg_addr, // addr
  input wire logic [7:0] reg_wdata, // wdata
  input wire logic [7:0] reg_rdata, // rdata
  input wire rtcpc_mem_req_type mem_req, // req
  input wire logic [7:0] mem_rdata, // rdata
  input wire rtcpc_time_type time_in, // ticks
  input wire logic supply_low, // fail
  input wire logic on_backup, // bat
  input wire logic ref_out_enable, // en
  input wire logic reset_pin_in, // pin
  input wire logic reset_pin_oe, // pull
  input wire logic irq_wave_pin_oe, // pull
  input wire logic calibrated_ref_oe // pull
);
  logic [7:0] ctrl;
  logic tk;
  logic hit;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  // Shadow of the control byte from the strobes, so no internal probe is needed
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= 8'h1c;
    end else if (reg_we && reg_addr == 8'h0e) begin
      ctrl <= reg_wdata;
    end
  end
  assign tk = time_in[2'h3 - ctrl[4:3]];
  assign hit = (time_in.alarm1_match && ctrl[0]) || (time_in.alarm2_match && ctrl[1]);
  a_fail_pull: assert property (supply_low |=> reset_pin_oe) else $error("no pull on fail");
  a_button_pull: assert property ($fell(reset_pin_in) && !reset_pin_oe && !supply_low |=> reset_pin_oe)
    else $error("no pull on button");
  a_hold_stable: assert property ($rose(reset_pin_oe) && !$past(supply_low) |=> reset_pin_oe [*8])
    else $error("pull dropped early");
  a_irq_alarm: assert property (ctrl[2] && hit |=> irq_wave_pin_oe) else $error("alarm missed");
  a_irq_quiet: assert property (ctrl[2] && !hit |=> !irq_wave_pin_oe) else $error("false alarm");
  // The pin follows the toggled level one cycle later, so the step shows two edges after the tick
  a_wave_step: assert property ((!ctrl[2] && tk ##1 !ctrl[2]) |=> $changed(irq_wave_pin_oe))
    else $error("wave missed tick");
  a_ref_step: assert property (ref_out_enable && time_in.tick_32k |=> $changed(calibrated_ref_oe))
    else $error("ref missed tick");
  a_reg_read: assert property (reg_addr == 8'h0e |=> reg_rdata == $past(ctrl)) else $error("bad read");
  a_reg_other: assert property (reg_addr != 8'h0e |=> reg_rdata == 8'h00) else $error("bad void");
endmodule
bind rtcpc_top rtcpc_asserts rtcpc_asserts_i (
  .ref_clk(ref_clk),
  .arst_n(arst_n),
  .write_protect(write_protect),
  .reg_we(reg_we),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .mem_req(mem_req),
  .mem_rdata(mem_rdata),
  .time_in(time_in),
  .supply_low(supply_low),
  .on_backup(on_backup),
  .ref_out_enable(ref_out_enable),
  .reset_pin_in(reset_pin_in),
  .reset_pin_oe(reset_pin_oe),
  .irq_wave_pin_oe(irq_wave_pin_oe),
  .calibrated_ref_oe(calibrated_ref_oe)
);

// ### test/rtcpc_board.sv
`timescale 1ns/10ps
module rtcpc_board (
  input wire logic reset_pin_oe, // device pull
  input wire logic button, // switch closed
  output logic reset_pin_in // pin level
);
  // Pulled up; either party may pull low
  assign reset_pin_in = !(reset_pin_oe || button);
endmodule

// ### test/rtc_pin_control_logic_bench.sv
`timescale 1ns/10ps
module rtc_pin_control_logic_bench
  import rtcpc_pkg::*;
;
  logic ref_clk = 1'b0, arst_n = 1'b0, reg_we = 1'b0, supply_low = 1'b0, on_backup = 1'b0;
  logic ref_out_enable = 1'b0, button = 1'b0, wp_drv = 1'b0, wp_val = 1'b0, prev;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, mem_rdata;
  logic reset_pin_in, reset_pin_oe, irq_wave_pin_oe, calibrated_ref_oe;
  rtcpc_mem_req_type mem_req = '0;
  rtcpc_time_type time_in = '0;
  tri0 wp_line;
  int fail_count = 0, cmp_count = 0, seed = 9, a;
  logic [7:0] ctrl = 8'h1c;
  int mem[int];
  assign wp_line = wp_drv ? wp_val : 1'bz;
  rtcpc_top rtcpc_top_i (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .write_protect(wp_line),
    .reg_we(reg_we),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .mem_req(mem_req),
    .mem_rdata(mem_rdata),
    .time_in(time_in),
    .supply_low(supply_low),
    .on_backup(on_backup),
    .ref_out_enable(ref_out_enable),
    .reset_pin_in(reset_pin_in),
    .reset_pin_oe(reset_pin_oe),
    .irq_wave_pin_oe(irq_wave_pin_oe),
    .calibrated_ref_oe(calibrated_ref_oe)
  );
  rtcpc_board rtcpc_board_i (
    .reset_pin_oe(reset_pin_oe),
    .button(button),
    .reset_pin_in(reset_pin_in)
  );
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk8(logic [7:0] g, logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(logic g, logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Host launches each transfer after one edge and holds it across the next
  task automatic wr(logic [7:0] ad, logic [7:0] dt);
    @(negedge ref_clk);
    reg_we = 1'b1;
    reg_addr = ad;
    reg_wdata = dt;
    @(negedge ref_clk);
    reg_we = 1'b0;
    if (ad == 8'h0e) ctrl = dt;
  endtask
  task automatic rd(logic [7:0] ad);
    @(negedge ref_clk);
    reg_addr = ad;
    @(negedge ref_clk);
    chk8(reg_rdata, ad == 8'h0e ? ctrl : 8'h00);
  endtask
  task automatic mw(int ad, int dt);
    @(negedge ref_clk);
    mem_req = {1'b1, ad[12:0], dt[7:0]};
    @(negedge ref_clk);
    mem_req.we = 1'b0;
    if (!(wp_drv && wp_val)) mem[ad] = dt;
  endtask
  task automatic pulse(int i);
    @(negedge ref_clk);
    time_in[i] = 1'b1;
    @(negedge ref_clk);
    time_in[i] = 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    time_in.alarm1_match = 1'b1;
    cyc(3);
    chk1(reset_pin_oe, 1'b1);
    chk1(irq_wave_pin_oe, 1'b0);
    rd(8'h0e);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h0e, 8'($random(seed)));
      rd(8'h0e);
      wr(8'h0f, 8'($random(seed)));
      rd(8'h0f);
    end
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      if (i % 4 == 0) wr(8'h0e, i < 4 ? 8'h05 : 8'h06);
      time_in.alarm1_match = i[0];
      time_in.alarm2_match = i[1];
      cyc(2);
      chk1(irq_wave_pin_oe, (i[0] & ctrl[0]) | (i[1] & ctrl[1]));
    end
    time_in = '0;
    $display("alarm test done");
    for (int r = 0; r < 4; r++) begin
      wr(8'h0e, 8'(r << 3));
      cyc(1);
      prev = irq_wave_pin_oe;
      pulse(3 - r);
      // Tick toggles the level, the pin register follows one edge later
      cyc(1);
      chk1(irq_wave_pin_oe, !prev);
      pulse(3 - ((r + 1) % 4));
      chk1(irq_wave_pin_oe, !prev);
    end
    $display("wave test done");
    ref_out_enable = 1'b1;
    for (int i = 0; i < 2; i++) begin
      on_backup = i[0];
      prev = calibrated_ref_oe;
      pulse(0);
      chk1(calibrated_ref_oe, !prev);
    end
    ref_out_enable = 1'b0;
    cyc(2);
    chk1(calibrated_ref_oe, 1'b0);
    $display("reference test done");
    for (int i = 0; i < 6; i++) begin
      a = $random(seed) & 32'h1fff;
      wp_drv = 1'b1;
      wp_val = 1'b0;
      mw(a, $random(seed));
      wp_drv = (i % 3 != 0);
      wp_val = (i % 3 == 2);
      mw(a, $random(seed));
      @(negedge ref_clk);
      mem_req = {1'b0, a[12:0], 8'h00};
      cyc(2);
      chk8(mem_rdata, mem[a][7:0]);
    end
    $display("array test done");
    wr(8'h0e, 8'h9c);
    for (int i = 0; i < 2; i++) begin
      supply_low = 1'b1;
      cyc(2);
      chk1(reset_pin_oe, 1'b1);
      supply_low = 1'b0;
      cyc(3);
      chk1(reset_pin_oe, 1'b0);
      button = 1'b1;
      cyc(2);
      chk1(reset_pin_oe, 1'b1);
      button = 1'b0;
      cyc(40);
      chk1(reset_pin_oe, 1'b1);
    end
    $display("reset pin test done");
    tally_and_finish;
  end
endmodule
